// File: logic/odc_output_ctrl.sv
`timescale 1ns/100ps

module odc_output_ctrl (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] reg_page,          // Selected register page
  input  wire logic [7:0] reg_addr,          // Register offset within page
  input  wire logic       reg_wr,            // Write strobe
  input  wire logic       reg_rd,            // Read strobe
  input  wire logic [7:0] reg_wdata,         // Write data
  output logic      [7:0] reg_rdata,         // Read data, valid after reg_rd
  // Fault detectors
  input  wire logic       hp_left_short,     // Short on left headphone driver
  input  wire logic       hp_right_short,    // Short on right headphone driver
  input  wire logic       spk_overcurrent,   // Speaker overcurrent
  input  wire logic       over_temp,         // Die overtemperature
  // Routing
  output logic            route_left_dac,    // Left converter into left stage
  output logic            route_right_dac,   // Right converter into right stage
  output logic            spk_left_to_amp,   // Left stage into mono amplifier
  output logic            spk_right_route,   // Right stage output enable
  // Volume stages
  output logic      [6:0] spk_left_code,     // Applied left code
  output logic      [6:0] spk_right_code,    // Applied right code
  output logic      [9:0] spk_left_atten,    // Left attenuation, 0.1 dB units
  output logic      [9:0] spk_right_atten,   // Right attenuation, 0.1 dB units
  output logic            spk_left_vol_mute, // Left stage muted
  output logic            spk_right_vol_mute,// Right stage muted
  output logic            vol_step_busy,     // A ramp is still moving
  // Headphone drivers
  output logic            left_headphone_driver_pwr,
  output logic            right_headphone_driver_pwr,
  output logic      [1:0] hp_cm_sel,         // Common-mode level select
  output logic            hp_lineout_mode,   // Reduced-power lineout
  output logic      [3:0] hp_left_gain,
  output logic      [3:0] hp_right_gain,
  output logic            hp_left_unmute,
  output logic            hp_right_unmute,
  output logic            hp_left_ilimit,    // Left current limiting active
  output logic            hp_right_ilimit,   // Right current limiting active
  // Speaker driver
  output logic            spk_pwr,           // Mono speaker power
  output logic            spk_switch_en,     // Output stage may switch
  output logic      [1:0] spk_gain,
  output logic            spk_unmute
);

  // All state but the ramp codes is one packed struct: one comb process builds the next
  // copy, one clocked process stores it
  odc_pkg::odc_state_s s_q;  // Registered state
  odc_pkg::odc_state_s s_d;  // Next state

  // Decoded strobes, synchronised faults, step timing
  logic       wr_p0;         // Write to page 0
  logic       wr_p1;         // Write to page 1
  logic       hp_l_flt;      // Synchronised left headphone short
  logic       hp_r_flt;      // Synchronised right headphone short
  logic       spk_flt;       // Synchronised speaker overcurrent
  logic       otp_flt;       // Synchronised overtemperature
  logic       base_tick;     // End of one base step period
  logic       step_en;       // Volume ramp enable
  logic       busy_l;
  logic       busy_r;

  // Attenuation in tenths of a dB for a 7-bit volume code
  // Three linear half-dB runs, the later two with a small offset, then a table
  // for the steep top end; codes past the table share the floor
  function automatic logic [9:0] vol_atten(input logic [6:0] code);
    logic [9:0] c;
    c = {3'h0, code};
    if (code <= 7'd35) begin
      vol_atten = 10'(c * 10'd5);
    end else if (code <= 7'd69) begin
      vol_atten = 10'(c * 10'd5 + 10'd1);
    end else if (code <= 7'd83) begin
      vol_atten = 10'(c * 10'd5 + 10'd2);
    end else begin
      unique case (code)
        7'd84:   vol_atten = 10'd421;
        7'd85:   vol_atten = 10'd427;
        7'd86:   vol_atten = 10'd432;
        7'd87:   vol_atten = 10'd438;
        7'd88:   vol_atten = 10'd443;
        7'd89:   vol_atten = 10'd448;
        7'd90:   vol_atten = 10'd452;
        7'd91:   vol_atten = 10'd458;
        7'd92:   vol_atten = 10'd462;
        7'd93:   vol_atten = 10'd467;
        7'd94:   vol_atten = 10'd474;
        7'd95:   vol_atten = 10'd479;
        7'd96:   vol_atten = 10'd482;
        7'd97:   vol_atten = 10'd487;
        7'd98:   vol_atten = 10'd493;
        7'd99:   vol_atten = 10'd500;
        7'd100:  vol_atten = 10'd503;
        7'd101:  vol_atten = 10'd510;
        7'd102:  vol_atten = 10'd514;
        7'd103:  vol_atten = 10'd518;
        7'd104:  vol_atten = 10'd522;
        7'd105:  vol_atten = 10'd527;
        7'd106:  vol_atten = 10'd537;
        7'd107:  vol_atten = 10'd542;
        7'd108:  vol_atten = 10'd553;
        7'd109:  vol_atten = 10'd567;
        7'd110:  vol_atten = 10'd583;
        7'd111:  vol_atten = 10'd602;
        7'd112:  vol_atten = 10'd627;
        7'd113:  vol_atten = 10'd643;
        7'd114:  vol_atten = 10'd662;
        7'd115:  vol_atten = 10'd687;
        7'd116:  vol_atten = 10'd722;
        default: vol_atten = 10'd783;  // Codes 117 to 127 share the floor
      endcase
    end
  endfunction : vol_atten

  // Stage mute: routing bit clear and code at the all-ones value
  // Uses the written code, not the ramped one, so mute is immediate
  function automatic logic vol_muted(input logic [7:0] vreg);
    vol_muted = !vreg[odc_pkg::VOL_ROUTE_BIT] && (vreg[6:0] == odc_pkg::VOL_CODE_MUTE);
  endfunction : vol_muted

  // Pages above one are not decoded, so writes there are lost
  // Page-qualified write strobes
  assign wr_p0 = reg_wr && (reg_page == odc_pkg::PAGE_0);
  assign wr_p1 = reg_wr && (reg_page == odc_pkg::PAGE_1);

  // Only the second synchroniser stage is used by the logic
  // Reading the first stage could let a metastable level reach the
  // status bits and the power-bit clears in the same cycle
  assign hp_l_flt = s_q.sync2[0];
  assign hp_r_flt = s_q.sync2[1];
  assign spk_flt  = s_q.sync2[2];
  assign otp_flt  = s_q.sync2[3];

  // Step field: 0 = base period, 1 = twice, 2 = four times, 3 = every clock
  // The divider free-runs from reset, so the first slow step may land
  // anywhere within one step period (up to four base periods) of a write; a short lag traded
  // for not restarting the count on every volume write
  assign base_tick = (s_q.base_cnt == odc_pkg::STEP_CNT_W'(odc_pkg::STEP_BASE_CYC - 1));

  // Step enable shared by both ramps
  always_comb begin
    unique case (s_q.step_ctrl[odc_pkg::STEP_TIME_LSB +: 2])
      2'h0: step_en = base_tick;
      2'h1: step_en = base_tick && s_q.sub_cnt[0];
      2'h2: step_en = base_tick && (s_q.sub_cnt == 2'h3);
      2'h3: step_en = 1'b1;
    endcase
  end

  // Next-state logic: register writes, protection, synchronisers, divider
  always_comb begin
    s_d = s_q;
    // Two-stage synchronisers for the analog detectors
    // Detector levels are sampled every clock, with no edge detection
    s_d.sync1 = {over_temp, spk_overcurrent, hp_right_short, hp_left_short};
    s_d.sync2 = s_q.sync1;

    // Step-rate divider
    // sub_cnt counts base periods for the two slower settings
    if (base_tick) begin
      s_d.base_cnt = '0;
      s_d.sub_cnt  = s_q.sub_cnt + 2'h1;
    end else begin
      s_d.base_cnt = s_q.base_cnt + odc_pkg::STEP_CNT_W'(1);
    end

    // Page 0 writes
    // Only the step-time register is writable on this page
    if (wr_p0 && (reg_addr == odc_pkg::VOLUME_STEP_TIME_CTRL_OFS)) begin
      s_d.step_ctrl = reg_wdata;
    end

    // Page 1 writes; status bit zero of the power registers is read-only
    // Bit zero is stored as zero; the live status is merged on reads
    if (wr_p1) begin
      unique case (reg_addr)
        // Writing one to a power bit also re-arms a tripped stage
        odc_pkg::HEADPHONE_POWER_CTRL_OFS: begin
          s_d.hp_pwr = {reg_wdata[7:1], 1'b0};
        end
        odc_pkg::SPEAKER_POWER_CTRL_OFS: begin
          s_d.spk_pwr = {reg_wdata[7:1], 1'b0};
        end
        odc_pkg::CONVERTER_OUTPUT_ROUTING_OFS: s_d.routing   = reg_wdata;
        odc_pkg::SPEAKER_LEFT_VOLUME_OFS:      s_d.spk_vol_l = reg_wdata;
        odc_pkg::SPEAKER_RIGHT_VOLUME_OFS:     s_d.spk_vol_r = reg_wdata;
        odc_pkg::HEADPHONE_LEFT_GAIN_OFS:      s_d.hp_gain_l = reg_wdata;
        odc_pkg::HEADPHONE_RIGHT_GAIN_OFS:     s_d.hp_gain_r = reg_wdata;
        odc_pkg::SPEAKER_GAIN_MUTE_OFS:        s_d.spk_gain  = reg_wdata;
        odc_pkg::HEADPHONE_DRIVE_CONFIG_OFS:   s_d.hp_cfg    = reg_wdata;
        default: ;  // Unmapped offsets are ignored
      endcase
    end

    // Shutdown mode: a live fault clears the power bit, even over a write,
    // so re-enabling into a standing short shuts down again at once
    // No retry count is kept: limiting retries is up to software
    if (s_q.hp_pwr[odc_pkg::HP_PROT_MODE_BIT]) begin
      if (hp_l_flt) begin
        s_d.hp_pwr[odc_pkg::HP_LEFT_PWR_BIT] = 1'b0;
      end
      if (hp_r_flt) begin
        s_d.hp_pwr[odc_pkg::HP_RIGHT_PWR_BIT] = 1'b0;
      end
    end

    // Speaker has no current-limit option: overcurrent always shuts down
    // A retry while the fault stands is cleared again at once
    if (spk_flt) begin
      s_d.spk_pwr[odc_pkg::SPK_PWR_BIT] = 1'b0;
    end

    // Read data is captured on the read strobe; unmapped reads return zero
    // A read and a write in one cycle return the old contents
    if (reg_rd) begin
      s_d.rdata = 8'h00;
      if (reg_page == odc_pkg::PAGE_0) begin
        // Thermal register: only bit one is live, the rest read zero
        if (reg_addr == odc_pkg::THERMAL_STATUS_OFS) begin
          s_d.rdata[odc_pkg::OTP_STATUS_BIT] = otp_flt;
        end else if (reg_addr == odc_pkg::VOLUME_STEP_TIME_CTRL_OFS) begin
          s_d.rdata = s_q.step_ctrl;
        end
      end else if (reg_page == odc_pkg::PAGE_1) begin
        unique case (reg_addr)
          odc_pkg::HEADPHONE_POWER_CTRL_OFS: begin
            // A short on either side shows in the one status bit
            s_d.rdata = {s_q.hp_pwr[7:1], hp_l_flt | hp_r_flt};
          end
          odc_pkg::SPEAKER_POWER_CTRL_OFS: begin
            s_d.rdata = {s_q.spk_pwr[7:1], spk_flt};
          end
          odc_pkg::CONVERTER_OUTPUT_ROUTING_OFS: s_d.rdata = s_q.routing;
          odc_pkg::SPEAKER_LEFT_VOLUME_OFS:      s_d.rdata = s_q.spk_vol_l;
          odc_pkg::SPEAKER_RIGHT_VOLUME_OFS:     s_d.rdata = s_q.spk_vol_r;
          odc_pkg::HEADPHONE_LEFT_GAIN_OFS:      s_d.rdata = s_q.hp_gain_l;
          odc_pkg::HEADPHONE_RIGHT_GAIN_OFS:     s_d.rdata = s_q.hp_gain_r;
          odc_pkg::SPEAKER_GAIN_MUTE_OFS:        s_d.rdata = s_q.spk_gain;
          odc_pkg::HEADPHONE_DRIVE_CONFIG_OFS:   s_d.rdata = s_q.hp_cfg;
          default:                               s_d.rdata = 8'h00;
        endcase
      end
    end
  end

  // State register; master reset clears every register
  // Asynchronous clear keeps the drivers off from the first instant
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Speaker-path volume ramps, one per channel
  // Both share one step enable, so they move in lockstep
  odc_soft_step u_step_left (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .step_en  (step_en),
    .target   (s_q.spk_vol_l[6:0]),
    .cur_code (spk_left_code),
    .busy     (busy_l)
  );

  odc_soft_step u_step_right (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .step_en  (step_en),
    .target   (s_q.spk_vol_r[6:0]),
    .cur_code (spk_right_code),
    .busy     (busy_r)
  );

  // Software may poll this to learn that a change has settled
  assign vol_step_busy = busy_l | busy_r;

  // Attenuation follows the applied, stepped code
  // Combinational from registered codes, settled within the cycle
  assign spk_left_atten     = vol_atten(spk_left_code);
  assign spk_right_atten    = vol_atten(spk_right_code);
  assign spk_left_vol_mute  = vol_muted(s_q.spk_vol_l);
  assign spk_right_vol_mute = vol_muted(s_q.spk_vol_r);

  // Routing
  assign route_left_dac  = s_q.routing[odc_pkg::ROUTE_LEFT_BIT];
  assign route_right_dac = s_q.routing[odc_pkg::ROUTE_RIGHT_BIT];
  assign spk_left_to_amp = s_q.spk_vol_l[odc_pkg::VOL_ROUTE_BIT];
  assign spk_right_route = s_q.spk_vol_r[odc_pkg::VOL_ROUTE_BIT];

  // Headphone drivers
  assign left_headphone_driver_pwr  = s_q.hp_pwr[odc_pkg::HP_LEFT_PWR_BIT];
  assign right_headphone_driver_pwr = s_q.hp_pwr[odc_pkg::HP_RIGHT_PWR_BIT];
  assign hp_cm_sel       = s_q.hp_pwr[odc_pkg::HP_CM_LSB +: 2];
  assign hp_lineout_mode = (s_q.hp_cfg[odc_pkg::LINEOUT_LSB +: 2] == odc_pkg::LINEOUT_MODE);
  assign hp_left_gain    = s_q.hp_gain_l[odc_pkg::HP_GAIN_LSB +: 4];
  assign hp_right_gain   = s_q.hp_gain_r[odc_pkg::HP_GAIN_LSB +: 4];
  assign hp_left_unmute  = s_q.hp_gain_l[odc_pkg::UNMUTE_BIT];
  assign hp_right_unmute = s_q.hp_gain_r[odc_pkg::UNMUTE_BIT];

  // Current limiting acts only in limit mode, while the short stands
  // The power bit stays set; the analog stage clamps the current
  assign hp_left_ilimit  = !s_q.hp_pwr[odc_pkg::HP_PROT_MODE_BIT] && hp_l_flt;
  assign hp_right_ilimit = !s_q.hp_pwr[odc_pkg::HP_PROT_MODE_BIT] && hp_r_flt;

  // Speaker driver; overtemperature only pauses switching, power bit kept
  // Switching resumes by itself once the synchronised flag drops
  assign spk_pwr       = s_q.spk_pwr[odc_pkg::SPK_PWR_BIT];
  assign spk_switch_en = spk_pwr && !otp_flt;
  assign spk_gain      = s_q.spk_gain[odc_pkg::SPK_GAIN_LSB +: 2];
  assign spk_unmute    = s_q.spk_gain[odc_pkg::UNMUTE_BIT];

  // Read data holds until the next read strobe
  assign reg_rdata = s_q.rdata;

endmodule : odc_output_ctrl

// File: logic/odc_pkg.sv
package odc_pkg;

  // Register pages
  localparam logic [7:0] PAGE_0 = 8'h00;
  localparam logic [7:0] PAGE_1 = 8'h01;

  // Page 0 register offsets
  localparam logic [7:0] THERMAL_STATUS_OFS        = 8'h03;
  localparam logic [7:0] VOLUME_STEP_TIME_CTRL_OFS = 8'h3F;

  // Page 1 register offsets
  localparam logic [7:0] HEADPHONE_POWER_CTRL_OFS     = 8'h1F;
  localparam logic [7:0] SPEAKER_POWER_CTRL_OFS       = 8'h20;
  localparam logic [7:0] CONVERTER_OUTPUT_ROUTING_OFS = 8'h23;
  localparam logic [7:0] SPEAKER_LEFT_VOLUME_OFS      = 8'h26;
  localparam logic [7:0] SPEAKER_RIGHT_VOLUME_OFS     = 8'h27;
  localparam logic [7:0] HEADPHONE_LEFT_GAIN_OFS      = 8'h28;
  localparam logic [7:0] HEADPHONE_RIGHT_GAIN_OFS     = 8'h29;
  localparam logic [7:0] SPEAKER_GAIN_MUTE_OFS        = 8'h2A;
  localparam logic [7:0] HEADPHONE_DRIVE_CONFIG_OFS   = 8'h2C;

  // Field positions
  localparam int STEP_TIME_LSB   = 0;  // Soft-step field, 2 bits
  localparam int HP_LEFT_PWR_BIT = 7;
  localparam int HP_RIGHT_PWR_BIT = 6;
  localparam int HP_CM_LSB       = 3;  // Common-mode field, 2 bits
  localparam int HP_PROT_MODE_BIT = 1;
  localparam int SHORT_STATUS_BIT = 0;
  localparam int SPK_PWR_BIT     = 7;
  localparam int ROUTE_LEFT_BIT  = 6;
  localparam int ROUTE_RIGHT_BIT = 2;
  localparam int VOL_ROUTE_BIT   = 7;  // Volume stage output routing / enable
  localparam int HP_GAIN_LSB     = 3;  // Headphone gain, 4 bits
  localparam int UNMUTE_BIT      = 2;  // 1 = driver unmuted
  localparam int SPK_GAIN_LSB    = 3;  // Speaker gain, 2 bits
  localparam int LINEOUT_LSB     = 1;  // Lineout mode field, 2 bits
  localparam int OTP_STATUS_BIT  = 1;

  // Values
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [1:0] LINEOUT_MODE   = 2'h3;
  localparam logic [6:0] VOL_CODE_MUTE  = 7'h7F;

  // Soft-step timing: one base step period, scaled by the step field
  localparam int CLK_PERIOD_NS   = 20;
  localparam int STEP_BASE_NS    = 20000;
  localparam int STEP_BASE_CYC   = (STEP_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_CNT_W      = $clog2(STEP_BASE_CYC);

  // Soft-step channel state
  typedef struct packed {
    logic [6:0] cur;  // Code currently applied to the volume stage
  } odc_step_s;

  // Block state
  typedef struct packed {
    logic [7:0]            step_ctrl;
    logic [7:0]            hp_pwr;
    logic [7:0]            spk_pwr;
    logic [7:0]            routing;
    logic [7:0]            spk_vol_l;
    logic [7:0]            spk_vol_r;
    logic [7:0]            hp_gain_l;
    logic [7:0]            hp_gain_r;
    logic [7:0]            spk_gain;
    logic [7:0]            hp_cfg;
    logic [7:0]            rdata;
    logic [3:0]            sync1;   // First synchroniser stage
    logic [3:0]            sync2;   // Second synchroniser stage
    logic [STEP_CNT_W-1:0] base_cnt;
    logic [1:0]            sub_cnt;
  } odc_state_s;

endpackage : odc_pkg

// File: logic/odc_soft_step.sv
`timescale 1ns/100ps

// One analog volume stage ramp: walks the applied code toward the target
module odc_soft_step (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       step_en,   // One-cycle step enable
  input  wire logic [6:0] target,    // Code written by software
  output logic      [6:0] cur_code,  // Code applied to the stage
  output logic            busy       // Ramp still moving
);

  odc_pkg::odc_step_s s_q;  // Registered state
  odc_pkg::odc_step_s s_d;  // Next state

  // Move one code per enable; never jumps, so no zipper noise on big changes
  always_comb begin
    s_d = s_q;
    if (step_en) begin
      if (s_q.cur < target) begin
        s_d.cur = s_q.cur + 7'h01;
      end else if (s_q.cur > target) begin
        s_d.cur = s_q.cur - 7'h01;
      end
    end
  end

  // State register; comes out of reset at full level, code zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cur_code = s_q.cur;
  assign busy     = (s_q.cur != target);

endmodule : odc_soft_step

// File: test/odc_output_ctrl_assertions.sv
`timescale 1ns/100ps

// Protocol and protection checks on the output control block ports
module odc_output_ctrl_chk (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [7:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       hp_left_short,
  input wire logic       spk_overcurrent,
  input wire logic       over_temp,
  input wire logic       route_left_dac,
  input wire logic [6:0] spk_left_code,
  input wire logic [9:0] spk_left_atten,
  input wire logic       spk_left_vol_mute,
  input wire logic       vol_step_busy,
  input wire logic       left_headphone_driver_pwr,
  input wire logic       hp_lineout_mode,
  input wire logic       hp_left_ilimit,
  input wire logic       spk_pwr,
  input wire logic       spk_switch_en
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_route;
    reg_wr && reg_page == 8'h01 && reg_addr == 8'h23
      |=> route_left_dac == (($past(reg_wdata) & 8'h40) != 8'h00);
  endproperty
  a_route: assert property (p_route)
    else $error("left route bit not taken from write");
  property p_mute;
    reg_wr && reg_page == 8'h01 && reg_addr == 8'h26
      |=> spk_left_vol_mute == ($past(reg_wdata) == 8'h7F);
  endproperty
  a_mute: assert property (p_mute)
    else $error("left stage mute wrong after write");
  property p_lineout;
    reg_wr && reg_page == 8'h01 && reg_addr == 8'h2C
      |=> hp_lineout_mode == (($past(reg_wdata) & 8'h06) == 8'h06);
  endproperty
  a_lineout: assert property (p_lineout)
    else $error("lineout mode wrong after write");
  // A ramp never jumps by more than one code per cycle
  property p_step;
    (spk_left_code == $past(spk_left_code)) || (spk_left_code == $past(spk_left_code) + 7'd1)
      || (spk_left_code == $past(spk_left_code) - 7'd1);
  endproperty
  a_step: assert property (p_step)
    else $error("applied code jumped");
  property p_busy;
    $changed(spk_left_code) |-> $past(vol_step_busy);
  endproperty
  a_busy: assert property (p_busy)
    else $error("code moved while not busy");
  property p_floor;
    spk_left_code == 7'h7F |-> spk_left_atten == 10'd783;
  endproperty
  a_floor: assert property (p_floor)
    else $error("top code attenuation wrong");
  // Current limiting absent with a steady short means shutdown mode
  property p_hp_off;
    hp_left_short [*3] ##0 !hp_left_ilimit |=> !left_headphone_driver_pwr;
  endproperty
  a_hp_off: assert property (p_hp_off)
    else $error("left headphone not shut down");
  property p_no_limit;
    !hp_left_short [*3] |-> !hp_left_ilimit;
  endproperty
  a_no_limit: assert property (p_no_limit)
    else $error("current limit without short");
  property p_spk_off;
    spk_overcurrent [*3] |=> !spk_pwr;
  endproperty
  a_spk_off: assert property (p_spk_off)
    else $error("speaker not shut down");
  property p_otp;
    over_temp [*3] |-> !spk_switch_en;
  endproperty
  a_otp: assert property (p_otp)
    else $error("speaker switching while hot");
  property p_otp_stat;
    over_temp [*3] ##0 (reg_rd && reg_page == 8'h00 && reg_addr == 8'h03) |=> reg_rdata == 8'h02;
  endproperty
  a_otp_stat: assert property (p_otp_stat)
    else $error("thermal status read wrong");
  property p_unmapped;
    reg_rd && reg_page > 8'h01 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped page read not zero");
endmodule : odc_output_ctrl_chk

bind odc_output_ctrl odc_output_ctrl_chk u_odc_output_ctrl_chk (.*);

// File: test/tb_odc_output_ctrl.sv
`timescale 1ns/100ps

module tb_odc_output_ctrl;
  // Stimulus, all given a value at time zero
  logic       clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_page = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       hp_left_short = 1'b0, hp_right_short = 1'b0;
  logic       spk_overcurrent = 1'b0, over_temp = 1'b0;
  // Observed outputs
  logic       route_left_dac, route_right_dac, spk_left_to_amp, spk_right_route;
  logic [6:0] spk_left_code, spk_right_code;
  logic [9:0] spk_left_atten, spk_right_atten;
  logic       spk_left_vol_mute, spk_right_vol_mute, vol_step_busy, hp_lineout_mode;
  logic       left_headphone_driver_pwr, right_headphone_driver_pwr;
  logic [1:0] hp_cm_sel, spk_gain;
  logic [3:0] hp_left_gain, hp_right_gain;
  logic       hp_left_unmute, hp_right_unmute, hp_left_ilimit, hp_right_ilimit;
  logic       spk_pwr, spk_switch_en, spk_unmute;
  int         bad_count = 0, n_compared = 0;
  // Page one registers and volume table samples
  logic [7:0] ofs [9] = '{8'h1F, 8'h20, 8'h23, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h2C};
  logic [6:0] codes [11] = '{0, 35, 36, 69, 70, 83, 84, 100, 116, 117, 127};
  logic [9:0] att [11] = '{0, 175, 181, 346, 352, 417, 421, 503, 722, 783, 783};

  always #10 clk_sys = ~clk_sys;

  odc_output_ctrl u_odc_output_ctrl (.*);

  task automatic print_verdict;
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One write strobe, released at the edge that takes it
  task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_page  <= pg;
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data lands at the taking edge, so look just after it
  task automatic rdchk(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_page <= pg;
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e);
  endtask : rdchk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // Bounded wait for all ramps; two base-period steps fit inside the bound
  task automatic idle;
    #1;
    for (int i = 0; i < 2200 && vol_step_busy !== 1'b0; i++) @(posedge clk_sys);
    #1;
  endtask : idle

  // Watchdog well beyond the expected run length
  initial begin
    #1ms;
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values, then write and read back; status bits stay clear
    for (int i = 0; i < 9; i++) rdchk(8'h01, ofs[i], 8'h00);
    for (int i = 0; i < 9; i++) begin
      wr(8'h01, ofs[i], 8'hA5);
      rdchk(8'h01, ofs[i], (i < 2) ? 8'hA4 : 8'hA5);
    end
    // Routing, driver fields and modes
    wr(8'h01, 8'h23, 8'h44);
    tick(1);
    check({route_left_dac, route_right_dac}, 2'b11);
    wr(8'h01, 8'h1F, 8'hDA);
    tick(1);
    check({left_headphone_driver_pwr, right_headphone_driver_pwr, hp_cm_sel}, 4'hF);
    wr(8'h01, 8'h1F, 8'h12);
    tick(1);
    check({left_headphone_driver_pwr, right_headphone_driver_pwr, hp_cm_sel}, 4'h2);
    wr(8'h01, 8'h28, 8'h7C);
    wr(8'h01, 8'h29, 8'h30);
    tick(1);
    check({hp_left_gain, hp_left_unmute, hp_right_gain, hp_right_unmute}, 10'h3EC);
    wr(8'h01, 8'h2A, 8'h1C);
    wr(8'h01, 8'h20, 8'h80);
    tick(1);
    check({spk_gain, spk_unmute, spk_pwr, spk_switch_en}, 5'h1F);
    wr(8'h01, 8'h2A, 8'h08);
    tick(1);
    check({spk_gain, spk_unmute}, 3'h2);
    wr(8'h01, 8'h2C, 8'h06);
    tick(1);
    check(hp_lineout_mode, 1'b1);
    wr(8'h01, 8'h2C, 8'h04);
    tick(1);
    check(hp_lineout_mode, 1'b0);
    wr(8'h01, 8'h26, 8'h7F);
    tick(1);
    check({spk_left_vol_mute, spk_left_to_amp}, 2'b10);
    // Volume table with the fastest ramp
    wr(8'h00, 8'h3F, 8'h03);
    rdchk(8'h00, 8'h3F, 8'h03);
    for (int i = 0; i < 11; i++) begin
      wr(8'h01, 8'h26, {1'b1, codes[i]});
      tick(1);
      if (i == 0) check(vol_step_busy, 1'b1);
      idle();
      check({spk_left_to_amp, spk_left_vol_mute, spk_left_code}, {2'b10, codes[i]});
      check(spk_left_atten, att[i]);
    end
    wr(8'h01, 8'h27, 8'h7B);
    idle();
    check({spk_right_route, spk_right_code}, 8'h7B);
    check({spk_right_vol_mute, spk_right_atten}, 11'h30F);
    // Base-period ramp setting still moving after ten cycles
    wr(8'h00, 8'h3F, 8'h00);
    wr(8'h01, 8'h26, 8'hFD);
    tick(10);
    check(vol_step_busy, 1'b1);
    idle();
    check(spk_left_code, 7'h7D);
    // Headphone short in shutdown mode, re-enable while present and after
    wr(8'h01, 8'h1F, 8'hDA);
    @(posedge clk_sys) hp_left_short <= 1'b1;
    tick(3);
    check({left_headphone_driver_pwr, right_headphone_driver_pwr, hp_left_ilimit}, 3'h2);
    rdchk(8'h01, 8'h1F, 8'h5B);
    wr(8'h01, 8'h1F, 8'hDA);
    tick(2);
    check(left_headphone_driver_pwr, 1'b0);
    @(posedge clk_sys) hp_left_short <= 1'b0;
    tick(3);
    // Second retry, now that the short has cleared
    wr(8'h01, 8'h1F, 8'hDA);
    rdchk(8'h01, 8'h1F, 8'hDA);
    // Current limiting mode keeps the driver powered
    wr(8'h01, 8'h1F, 8'hD8);
    @(posedge clk_sys) hp_right_short <= 1'b1;
    tick(3);
    check({hp_right_ilimit, right_headphone_driver_pwr}, 2'b11);
    @(posedge clk_sys) hp_right_short <= 1'b0;
    // Speaker overcurrent and recovery
    @(posedge clk_sys) spk_overcurrent <= 1'b1;
    tick(3);
    check(spk_pwr, 1'b0);
    rdchk(8'h01, 8'h20, 8'h01);
    @(posedge clk_sys) spk_overcurrent <= 1'b0;
    tick(3);
    wr(8'h01, 8'h20, 8'h80);
    tick(1);
    check(spk_pwr, 1'b1);
    // Overheat stops switching without touching the power bit
    @(posedge clk_sys) over_temp <= 1'b1;
    tick(3);
    check({spk_pwr, spk_switch_en}, 2'b10);
    rdchk(8'h00, 8'h03, 8'h02);
    @(posedge clk_sys) over_temp <= 1'b0;
    tick(3);
    check(spk_switch_en, 1'b1);
    // Read-only and unmapped places
    wr(8'h00, 8'h03, 8'hFF);
    rdchk(8'h00, 8'h03, 8'h00);
    rdchk(8'h02, 8'h1F, 8'h00);
    rdchk(8'h01, 8'h00, 8'h00);
    print_verdict();
  end
endmodule : tb_odc_output_ctrl
